// ==== logic/refsw_pkg.sv ====
// shared constants and types of the reference switchover control
package refsw_pkg;
  localparam int NREF = 8;
  localparam int IDXW = 3;
  localparam int NREG = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRIO = 8'h04;
  localparam logic [7:0] OFF_PSL = 8'h08;
  localparam logic [7:0] OFF_MAXDEV = 8'h0C;
  localparam logic [7:0] OFF_QL_EN = 8'h10;
  localparam logic [7:0] OFF_QL_RELAX = 8'h14;
  localparam logic [7:0] OFF_QL_FSL = 8'h18;
  localparam logic [7:0] OFF_BW = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // channel_control_word fields
  localparam int MODE_LSB = 0;
  localparam int MAN_LSB = 4;
  localparam int FOL_LSB = 8;
  localparam int REV_BIT = 12;
  localparam int HS_EN_BIT = 13;
  localparam int HS_TYPE_BIT = 14;
  localparam int PSL_EN_BIT = 15;
  // other field positions
  localparam int PRIO_W = 4;
  localparam int QL_PSL_LSB = 16;
  localparam int QL_REC_LSB = 4;
  localparam int PREACQ_EN_BIT = 8;
  localparam int PREACQ_MS_LSB = 16;
  localparam int FSL_EN_BIT = 16;
  localparam int QL_BW_LSB = 8;
  // reference mode codes
  localparam logic [3:0] MODE_AUTO = 4'h0;
  localparam logic [3:0] MODE_MANUAL = 4'h1;
  localparam logic [3:0] MODE_PIN = 4'h2;
  localparam logic [3:0] MODE_FOLLOW = 4'h3;
  localparam logic [3:0] MODE_PINFOL = 4'h4;
  // reset values and writable masks, indexed by offset / 4
  localparam logic [31:0] REG_RST [NREG] = '{32'h0000_0000, 32'h7654_3210, 32'h0000_0000,
    32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] REG_WMASK [NREG] = '{32'h0000_F77F, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'h00FF_01FF, 32'h0000_0007, 32'h0001_FFFF, 32'h0000_FFFF};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pre-acquisition time unit and clock period
  localparam int PREACQ_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  typedef enum logic [2:0] {
    ST_FREERUN, ST_LOCK_ACQUISITION_STATE, ST_LOCKED, ST_HOLDOVER, ST_LOCK_RECOVERY_STATE, ST_HS_MEAS
  } chan_state_e;
  typedef enum logic [2:0] {
    AID_IDLE, AID_FSNAP, AID_PSNAP, AID_OLPULL, AID_PREACQ, AID_WIDE, AID_DONE
  } aid_e;
endpackage

// ==== logic/pin_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and synchronised levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end
  assign pin_sync = sync_ff;
endmodule

// ==== logic/refsw_ctrl.sv ====
// per-channel reference selection, hitless switch and fast-lock sequencing
// Functional notes
// - manual mode follows chosen index, ignores other monitors
// - manual reference lost means holdover regardless
// - follower mode uses only follower index
// - follower pin switches to follower reference
// - revertive bit, non-revertive after reset
// - pick highest-priority valid reference, then lock
// - non-revertive switches only when current fails
// - revertive switches up, not within group
// - hitless on locked switch or holdover exit
// - hitless measure in silent temporary holdover
// - measured offset becomes detector zero point
// - holdover exit measures before closing loop
// - two selectable hitless switch variants
// - phase slope limit enable and value
// - clamp frequency deviation while locking, switching
// - four aids, each enabled, acquisition or recovery
// - one aid at a time, fixed precedence
// - frequency snap with optional slope limit
// - phase snap or open-loop pull-in
// - wide acquisition relaxes chosen limits until lock
// - pre-acquisition timed maximum bandwidth, acquisition only
// - four-bit reference mode encoding
// - free-run to acquisition, holdover to recovery
`timescale 1ns/100ps
module refsw_ctrl #(
  parameter int unsigned MS_CYCLES = refsw_pkg::PREACQ_UNIT_NS / refsw_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // reference monitors and pins
  input wire logic [refsw_pkg::NREF-1:0] ref_valid,
  input wire logic pin_manual_select_bit0,
  input wire logic pin_manual_select_bit1,
  input wire logic pin_manual_select_bit2,
  input wire logic pin_follower_status,
  // loop status
  input wire logic loop_locked,
  input wire logic phase_meas_done,
  input wire logic aid_done,
  // selection and state
  output logic [refsw_pkg::IDXW-1:0] selected_ref,
  output logic ref_engaged,
  output logic [2:0] chan_state,
  output logic holdover_alarm,
  output logic loop_hold,
  output logic phase_meas_start,
  output logic pd_zero_load,
  output logic hs_type2,
  // loop limits and fast-lock aids
  output logic freq_clamp_en,
  output logic [31:0] max_frequency_deviation,
  output logic psl_enable,
  output logic [15:0] psl_value,
  output logic [7:0] bandwidth_code,
  output logic bw_max,
  output logic damping_relax,
  output logic freq_snap_req,
  output logic [15:0] freq_slope_limit,
  output logic freq_slope_limit_en,
  output logic phase_snap_req,
  output logic open_loop_pull,
  output logic pre_acq,
  output logic wide_acq
);
  import refsw_pkg::*;

  logic [31:0] reg_ff [NREG];
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [IDXW-1:0] sel_ff;
  logic have_ref_ff;
  chan_state_e state_ff;
  chan_state_e nxt_state;
  aid_e aid_ff;
  aid_e nxt_aid;
  logic meas_start_ff;
  logic zero_load_ff;
  logic [7:0] ms_left_ff;
  logic [31:0] cyc_ff;
  logic [3:0] pins_s;
  logic [IDXW-1:0] best_idx;
  logic [PRIO_W-1:0] best_pr;
  logic best_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r & m;
  endfunction

  function automatic aid_e next_aid(input aid_e cur, input logic [4:0] ok);
    if (cur < AID_FSNAP && ok[0]) return AID_FSNAP;
    if (cur < AID_PSNAP && ok[1]) return AID_PSNAP;
    if (cur < AID_OLPULL && ok[2]) return AID_OLPULL;
    if (cur < AID_PREACQ && ok[3]) return AID_PREACQ;
    if (cur < AID_WIDE && ok[4]) return AID_WIDE;
    return AID_DONE;
  endfunction

  pin_sync #(.W(4)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({pin_follower_status, pin_manual_select_bit2, pin_manual_select_bit1, pin_manual_select_bit0}),
    .pin_sync(pins_s)
  );

  // bus decode
  wire wr_go = awvalid && wvalid && !bvalid_ff;
  wire rd_go = arvalid && !rvalid_ff;
  wire wr_map = awaddr[7:5] == 3'h0 && awaddr[1:0] == 2'h0;
  wire wr_stat = awaddr == OFF_STATUS;
  wire rd_map = araddr[7:5] == 3'h0 && araddr[1:0] == 2'h0;
  wire rd_stat = araddr == OFF_STATUS;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;

  // register fields
  wire [31:0] ctrl = reg_ff[OFF_CTRL[4:2]];
  wire [31:0] prio = reg_ff[OFF_PRIO[4:2]];
  wire [31:0] pslr = reg_ff[OFF_PSL[4:2]];
  wire [31:0] qlen = reg_ff[OFF_QL_EN[4:2]];
  wire [31:0] relax = reg_ff[OFF_QL_RELAX[4:2]];
  wire [31:0] fslr = reg_ff[OFF_QL_FSL[4:2]];
  wire [31:0] bwr = reg_ff[OFF_BW[4:2]];
  wire [3:0] mode = ctrl[MODE_LSB +: 4];
  wire [IDXW-1:0] man_idx = ctrl[MAN_LSB +: IDXW];
  wire [IDXW-1:0] fol_idx = ctrl[FOL_LSB +: IDXW];
  wire rev = ctrl[REV_BIT];
  wire hs_en = ctrl[HS_EN_BIT];
  wire [IDXW-1:0] pin_idx = pins_s[2:0];
  wire follow_pin = pins_s[3];

  wire fol_now = mode == MODE_FOLLOW || (mode == MODE_PINFOL && follow_pin);
  wire fixed_mode = mode == MODE_MANUAL || mode == MODE_PIN || fol_now;
  wire [IDXW-1:0] fixed_idx = fol_now ? fol_idx : (mode == MODE_PIN ? pin_idx : man_idx);

  // highest priority valid reference, lowest value wins
  always_comb begin
    best_idx = '0;
    best_pr = '0;
    best_ok = 1'b0;
    for (int i = 0; i < NREF; i++) begin
      if (ref_valid[i] && (!best_ok || prio[i*PRIO_W +: PRIO_W] < best_pr)) begin
        best_ok = 1'b1;
        best_idx = IDXW'(i);
        best_pr = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end

  wire [PRIO_W-1:0] cur_pr = prio[{sel_ff, 2'b00} +: PRIO_W];
  wire cur_ok = have_ref_ff && ref_valid[sel_ff];
  // switch on loss, or upward when revertive outside the group
  wire prio_switch = best_ok && (!cur_ok || (rev && best_pr < cur_pr));
  // fixed reference invalid leaves no target
  wire tgt_ok = fixed_mode ? ref_valid[fixed_idx] : (cur_ok || best_ok);
  wire [IDXW-1:0] tgt_idx = fixed_mode ? fixed_idx : (prio_switch ? best_idx : sel_ff);
  wire switching = have_ref_ff && tgt_ok && tgt_idx != sel_ff;
  wire in_acqrec = state_ff == ST_LOCK_ACQUISITION_STATE || state_ff == ST_LOCK_RECOVERY_STATE;

  // channel state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_FREERUN: if (tgt_ok) nxt_state = ST_LOCK_ACQUISITION_STATE;
      ST_LOCK_ACQUISITION_STATE: begin
        if (!tgt_ok) nxt_state = ST_FREERUN;
        else if (loop_locked && !switching) nxt_state = ST_LOCKED;
      end
      ST_LOCK_RECOVERY_STATE: begin
        if (!tgt_ok) nxt_state = ST_HOLDOVER;
        else if (loop_locked && !switching) nxt_state = ST_LOCKED;
      end
      ST_LOCKED: begin
        if (!tgt_ok) nxt_state = ST_HOLDOVER;
        // hitless on a change while locked
        else if (switching) nxt_state = hs_en ? ST_HS_MEAS : ST_LOCK_RECOVERY_STATE;
      end
      ST_HOLDOVER: begin
        if (tgt_ok) nxt_state = hs_en ? ST_HS_MEAS : ST_LOCK_RECOVERY_STATE;
      end
      ST_HS_MEAS: begin
        if (!tgt_ok) nxt_state = ST_HOLDOVER;
        else if (phase_meas_done && !switching) nxt_state = ST_LOCK_RECOVERY_STATE;
      end
      default: nxt_state = ST_FREERUN;
    endcase
  end

  // aids fitting the state being entered
  wire is_rec = nxt_state == ST_LOCK_RECOVERY_STATE;
  wire [3:0] ql_fit = qlen[3:0] & (is_rec ? qlen[QL_REC_LSB +: 4] : ~qlen[QL_REC_LSB +: 4]);
  wire [4:0] aid_ok = {ql_fit[3], qlen[PREACQ_EN_BIT] && !is_rec, ql_fit[2] && !ql_fit[1], ql_fit[1], ql_fit[0]};
  wire acqrec_nxt = nxt_state == ST_LOCK_ACQUISITION_STATE || nxt_state == ST_LOCK_RECOVERY_STATE;
  wire entering = acqrec_nxt && (!in_acqrec || switching);
  wire snap_step = aid_ff == AID_FSNAP || aid_ff == AID_PSNAP || aid_ff == AID_OLPULL;
  wire step_done = (snap_step && aid_done) || (aid_ff == AID_PREACQ && ms_left_ff == 8'h00);

  // one aid at a time in precedence order
  always_comb begin
    nxt_aid = aid_ff;
    if (!acqrec_nxt) nxt_aid = AID_IDLE;
    else if (entering) nxt_aid = next_aid(AID_IDLE, aid_ok);
    else if (step_done) nxt_aid = next_aid(aid_ff, aid_ok);
  end

  // registers and bus responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < NREG; r++) begin
        reg_ff[r] <= REG_RST[r];
      end
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (wr_go && wr_map) begin
        reg_ff[awaddr[4:2]] <= merge(reg_ff[awaddr[4:2]], wdata, wstrb, REG_WMASK[awaddr[4:2]]);
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_map || wr_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  wire [31:0] status = {13'h0000, aid_ff, ref_valid, 1'b0, have_ref_ff, sel_ff, state_ff};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= (rd_map || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rd_stat ? status : (rd_map ? reg_ff[araddr[4:2]] : 32'h0000_0000);
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // selection follows sampled validity on the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ff <= '0;
      have_ref_ff <= 1'b0;
      state_ff <= ST_FREERUN;
      aid_ff <= AID_IDLE;
      meas_start_ff <= 1'b0;
      zero_load_ff <= 1'b0;
    end else begin
      if (tgt_ok) begin
        sel_ff <= tgt_idx;
      end
      have_ref_ff <= tgt_ok;
      state_ff <= nxt_state;
      aid_ff <= nxt_aid;
      // start phase measurement on entry or reference change
      meas_start_ff <= nxt_state == ST_HS_MEAS && (state_ff != ST_HS_MEAS || switching);
      // load measured offset as detector zero
      zero_load_ff <= state_ff == ST_HS_MEAS && tgt_ok && phase_meas_done && !switching;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_left_ff <= 8'h00;
      cyc_ff <= 32'h0000_0000;
    end else if (nxt_aid == AID_PREACQ && aid_ff != AID_PREACQ) begin
      ms_left_ff <= qlen[PREACQ_MS_LSB +: 8];
      cyc_ff <= 32'(MS_CYCLES - 1);
    end else if (aid_ff == AID_PREACQ && ms_left_ff != 8'h00) begin
      if (cyc_ff == 32'h0000_0000) begin
        cyc_ff <= 32'(MS_CYCLES - 1);
        ms_left_ff <= ms_left_ff - 8'h01;
      end else begin
        cyc_ff <= cyc_ff - 32'h0000_0001;
      end
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign selected_ref = sel_ff;
  assign ref_engaged = have_ref_ff;
  assign chan_state = state_ff;
  assign holdover_alarm = state_ff == ST_HOLDOVER;
  assign loop_hold = state_ff == ST_HOLDOVER || state_ff == ST_HS_MEAS;
  assign phase_meas_start = meas_start_ff;
  assign pd_zero_load = zero_load_ff;
  assign hs_type2 = ctrl[HS_TYPE_BIT];
  // deviation clamp while locking, holding or switching
  assign freq_clamp_en = state_ff != ST_FREERUN && state_ff != ST_LOCKED;
  assign max_frequency_deviation = reg_ff[OFF_MAXDEV[4:2]];
  assign freq_snap_req = aid_ff == AID_FSNAP;
  assign freq_slope_limit = fslr[15:0];
  assign freq_slope_limit_en = fslr[FSL_EN_BIT] && freq_snap_req;
  assign phase_snap_req = aid_ff == AID_PSNAP;
  assign open_loop_pull = aid_ff == AID_OLPULL;
  // relaxed limits during wide and pre-acquisition
  assign pre_acq = aid_ff == AID_PREACQ;
  assign wide_acq = aid_ff == AID_WIDE;
  assign bw_max = pre_acq;
  wire tmp_psl = pre_acq || (wide_acq && relax[1]);
  assign bandwidth_code = (wide_acq && relax[0]) ? bwr[QL_BW_LSB +: 8] : bwr[7:0];
  assign damping_relax = wide_acq && relax[2];
  // slope limit, temporary value while relaxed
  assign psl_enable = ctrl[PSL_EN_BIT] || tmp_psl;
  assign psl_value = tmp_psl ? pslr[QL_PSL_LSB +: 16] : pslr[15:0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_manual_follow;
    (mode == MODE_MANUAL && ref_valid[man_idx]) |=> (have_ref_ff && sel_ff == $past(man_idx));
  endproperty
  a_manual_follow: assert property (p_manual_follow) else $error("manual reference not followed");

  property p_manual_loss;
    (mode == MODE_MANUAL && !ref_valid[man_idx] && state_ff == ST_LOCKED) |=> state_ff == ST_HOLDOVER;
  endproperty
  a_manual_loss: assert property (p_manual_loss) else $error("manual loss did not hold over");

  property p_follower;
    (mode == MODE_FOLLOW && ref_valid[fol_idx]) |=> sel_ff == $past(fol_idx);
  endproperty
  a_follower: assert property (p_follower) else $error("follower reference not used");

  property p_nonrev_hold;
    (mode == MODE_AUTO && !rev && cur_ok) |=> $stable(sel_ff);
  endproperty
  a_nonrev_hold: assert property (p_nonrev_hold) else $error("non-revertive switched");

  property p_rev_up;
    (mode == MODE_AUTO && rev && cur_ok && best_ok && best_pr < cur_pr) |=> sel_ff == $past(best_idx);
  endproperty
  a_rev_up: assert property (p_rev_up) else $error("revertive did not switch up");

  property p_meas_quiet;
    state_ff == ST_HS_MEAS |-> (!holdover_alarm && loop_hold);
  endproperty
  a_meas_quiet: assert property (p_meas_quiet) else $error("alarm during hitless measure");

  sequence s_meas_end;
    state_ff == ST_HS_MEAS && tgt_ok && phase_meas_done && !switching;
  endsequence
  property p_zero_load;
    s_meas_end |=> (pd_zero_load && state_ff == ST_LOCK_RECOVERY_STATE);
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("offset not loaded as zero");

  sequence s_ho_exit;
    state_ff == ST_HOLDOVER && tgt_ok && hs_en;
  endsequence
  property p_ho_measure;
    s_ho_exit |=> (state_ff == ST_HS_MEAS && phase_meas_start);
  endproperty
  a_ho_measure: assert property (p_ho_measure) else $error("holdover exit skipped measure");

  property p_one_aid;
    $onehot0({freq_snap_req, phase_snap_req, open_loop_pull, pre_acq, wide_acq});
  endproperty
  a_one_aid: assert property (p_one_aid) else $error("two fast-lock aids active");

  property p_preacq_state;
    pre_acq |-> (state_ff == ST_LOCK_ACQUISITION_STATE && bw_max);
  endproperty
  a_preacq_state: assert property (p_preacq_state) else $error("pre-acquisition outside acquisition");

  property p_freerun_acq;
    (state_ff == ST_FREERUN && tgt_ok) |=> state_ff == ST_LOCK_ACQUISITION_STATE;
  endproperty
  a_freerun_acq: assert property (p_freerun_acq) else $error("free-run did not enter acquisition");
endmodule

// ==== verif/ref_source_model.sv ====
// far-side model: reference monitors, master pins and loop feedback
`timescale 1ns/100ps
module ref_source_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench commands
  input wire logic [7:0] valid_cmd,
  input wire logic [2:0] pin_cmd,
  input wire logic follow_cmd,
  input wire logic [7:0] answer_delay,
  // channel status
  input wire logic [2:0] chan_state,
  input wire logic [3:0] aid_busy,
  // far-side signals
  output logic [7:0] ref_valid,
  output logic [2:0] pin_sel,
  output logic pin_follow,
  output logic loop_locked,
  output logic phase_meas_done,
  output logic aid_done
);
  logic [6:0] sig_ff;
  logic [7:0] cnt_ff;
  wire logic [6:0] sig = {chan_state, aid_busy};
  // answers only once the channel has held still for the chosen delay
  wire logic ripe = (sig == sig_ff) && (cnt_ff >= answer_delay);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_ff <= '0;
      cnt_ff <= '0;
    end else begin
      sig_ff <= sig;
      cnt_ff <= (sig != sig_ff) ? 8'h00 : (ripe ? cnt_ff : cnt_ff + 8'h01);
    end
  end
  assign ref_valid = valid_cmd;
  assign pin_sel = pin_cmd;
  assign pin_follow = follow_cmd;
  // lock is reported only once snaps, pull-in and pre-acquisition are over
  assign loop_locked = (chan_state == 3'h2) ||
    ((chan_state == 3'h1 || chan_state == 3'h4) && aid_busy == 4'h0 && ripe);
  assign phase_meas_done = (chan_state == 3'h5) && ripe;
  assign aid_done = (aid_busy[2:0] != 3'h0) && ripe;
endmodule

// ==== verif/refsw_ctrl_tb.sv ====
// self-checking bench of the reference switchover control
`timescale 1ns/100ps
module refsw_ctrl_tb;
  import refsw_pkg::*;
  localparam int unsigned MS_TB = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] valid_cmd = 8'h00;
  logic [2:0] pin_cmd = 3'h0;
  logic follow_cmd = 1'b0;
  logic [7:0] answer_delay = 8'h04;
  logic awready, bvalid, arready, rvalid, pin_follow, loop_locked, phase_meas_done, aid_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, max_frequency_deviation;
  logic [7:0] ref_valid;
  logic [2:0] pin_sel, selected_ref, chan_state;
  logic holdover_alarm, loop_hold, pd_zero_load, hs_type2, freq_clamp_en, psl_enable;
  logic [15:0] psl_value;
  logic freq_snap_req, phase_snap_req, open_loop_pull, pre_acq, wide_acq;
  logic wready, ref_engaged, phase_meas_start, bw_max, damping_relax, freq_slope_limit_en;
  logic [7:0] bandwidth_code;
  logic [15:0] freq_slope_limit;
  logic saw_ms = 1'b0;
  logic [25:0] wide_cfg = '0;
  logic [17:0] pre_cfg = '0;
  logic [16:0] fsl_cfg = '0;
  logic saw_fs = 1'b0;
  logic saw_ps = 1'b0;
  logic saw_ol = 1'b0;
  logic saw_pz = 1'b0;
  logic multi = 1'b0;
  int pre_cnt = 0;
  int bad_count = 0;
  int n_tests = 0;

  refsw_ctrl #(.MS_CYCLES(MS_TB)) i_refsw_ctrl (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .ref_valid, .pin_manual_select_bit0(pin_sel[0]), .pin_manual_select_bit1(pin_sel[1]),
    .pin_manual_select_bit2(pin_sel[2]), .pin_follower_status(pin_follow), .loop_locked,
    .phase_meas_done, .aid_done, .selected_ref, .ref_engaged, .chan_state, .holdover_alarm,
    .loop_hold, .phase_meas_start, .pd_zero_load, .hs_type2, .freq_clamp_en, .max_frequency_deviation,
    .psl_enable, .psl_value, .bandwidth_code, .bw_max, .damping_relax, .freq_snap_req,
    .freq_slope_limit, .freq_slope_limit_en, .phase_snap_req, .open_loop_pull, .pre_acq, .wide_acq
  );

  ref_source_model i_ref_source_model (
    .aclk, .aresetn, .valid_cmd, .pin_cmd, .follow_cmd, .answer_delay, .chan_state,
    .aid_busy({pre_acq, open_loop_pull, phase_snap_req, freq_snap_req}), .ref_valid, .pin_sel,
    .pin_follow, .loop_locked, .phase_meas_done, .aid_done
  );

  always #5 aclk = ~aclk;

  // sticky record of aid and zero-load activity
  always @(posedge aclk) begin
    if (freq_snap_req === 1'b1) saw_fs <= 1'b1;
    if (phase_snap_req === 1'b1) saw_ps <= 1'b1;
    if (open_loop_pull === 1'b1) saw_ol <= 1'b1;
    if (pd_zero_load === 1'b1) saw_pz <= 1'b1;
    if (pre_acq === 1'b1) pre_cnt <= pre_cnt + 1;
    if (phase_meas_start === 1'b1) saw_ms <= 1'b1;
    if (wide_acq === 1'b1) wide_cfg <= {damping_relax, psl_enable, bandwidth_code, psl_value};
    if (pre_acq === 1'b1) pre_cfg <= {bw_max, psl_enable, psl_value};
    if (freq_snap_req === 1'b1) fsl_cfg <= {freq_slope_limit_en, freq_slope_limit};
    if ($countones({freq_snap_req, phase_snap_req, open_loop_pull, pre_acq, wide_acq}) > 1) multi <= 1'b1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released on the edge its own ready is seen
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1) aw_ok = 1'b1;
      if (wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, RESP_OKAY);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
    @(posedge aclk);
  endtask

  task automatic wst(input logic [2:0] s);
    int n;
    n = 0;
    while (chan_state !== s && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk(chan_state, s);
  endtask

  task automatic final_report();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_PRIO, 32'h7654_3210, RESP_OKAY);
    rd(8'h24, 32'h0, RESP_SLVERR);
    chk(max_frequency_deviation, 32'h0000_FFFF);
    // acquisition from free-run, every aid enabled, open-loop pull-in skipped, 1 ms pre-acquisition
    wr(OFF_QL_EN, 32'h0001_010F);
    wr(OFF_QL_RELAX, 32'h0000_0007);
    wr(OFF_QL_FSL, 32'h0001_0009);
    wr(OFF_BW, 32'h0000_2010);
    wr(OFF_PSL, 32'h0005_0003);
    wr(OFF_CTRL, 32'h0000_8000);
    valid_cmd <= 8'h08;
    wst(3'h1);
    chk({ref_engaged, selected_ref}, 4'hB);
    wst(3'h2);
    chk({saw_fs, saw_ps, saw_ol, multi}, 4'hC);
    chk(pre_cnt, MS_TB + 1);
    chk(wide_acq, 1'b0);
    chk({psl_enable, psl_value}, {1'b1, 16'h0003});
    chk(bandwidth_code, 8'h10);
    chk(wide_cfg, 26'h320_0005);
    chk(pre_cfg, 18'h3_0005);
    chk(fsl_cfg, 17'h1_0009);
    rd(OFF_STATUS, 32'h0000_085A, RESP_OKAY);
    // a better reference returns while non-revertive
    valid_cmd <= 8'h09;
    tick(6);
    chk(selected_ref, 3'h3);
    wr(OFF_CTRL, 32'h0000_1000);
    wst(3'h4);
    chk(selected_ref, 3'h0);
    wst(3'h2);
    // ref0 and ref1 share one priority group
    wr(OFF_PRIO, 32'h7654_3200);
    valid_cmd <= 8'h02;
    wst(3'h4);
    chk(selected_ref, 3'h1);
    wst(3'h2);
    valid_cmd <= 8'h03;
    tick(6);
    chk(selected_ref, 3'h1);
    // hitless switch while locked, slow measurement
    wr(OFF_CTRL, 32'h0000_7000);
    answer_delay <= 8'h0C;
    valid_cmd <= 8'h08;
    wst(3'h5);
    chk({holdover_alarm, loop_hold, hs_type2}, 3'h3);
    wst(3'h4);
    wst(3'h2);
    chk({saw_ms, saw_pz}, 2'h3);
    // manual index 5 ignores the better ref3, then loses ref5
    valid_cmd <= 8'h28;
    tick(4);
    wr(OFF_CTRL, 32'h0000_2051);
    wst(3'h5);
    chk(selected_ref, 3'h5);
    wst(3'h2);
    valid_cmd <= 8'h08;
    wst(3'h3);
    chk({ref_engaged, holdover_alarm, freq_clamp_en}, 3'h3);
    valid_cmd <= 8'h28;
    wst(3'h5);
    wst(3'h4);
    wst(3'h2);
    // pin, follower, pin-follower and a reserved mode code
    answer_delay <= 8'h02;
    valid_cmd <= 8'hFB;
    pin_cmd <= 3'h6;
    wr(OFF_CTRL, 32'h0000_0002);
    tick(4);
    chk(selected_ref, 3'h6);
    wr(OFF_CTRL, 32'h0000_0203);
    tick(4);
    chk({selected_ref, chan_state}, {3'h6, 3'h3});
    wr(OFF_CTRL, 32'h0000_0704);
    tick(4);
    chk(selected_ref, 3'h0);
    follow_cmd <= 1'b1;
    tick(5);
    chk(selected_ref, 3'h7);
    wr(OFF_CTRL, 32'h0000_1005);
    tick(4);
    chk(selected_ref, 3'h0);
    chk(pre_cnt, MS_TB + 1);
    final_report();
  end
endmodule
